// ===== bench/tb_tlac_core.sv
`timescale 1ns/100ps
module tb_tlac_core;
   logic        clk, link_clk, reset_n = 1'b0, link_wr = 1'b0, link_rd = 1'b0;
   logic [7:0]  link_ptr = 8'h00;
   logic [15:0] link_wdata = 16'h0000, link_rdata, rd;
   logic [12:0] temp = 13'h0000, conv_temp;
   logic        link_done, link_busy, conv_valid, conv_enable, alert_pin_out, alert_pin_oe_n;
   int          n_fail = 0, comparisons = 0, i;
   logic [15:0] cw [15] = '{16'h0208, 16'h020A, 16'h0208, 16'h0228, 16'h0208, 16'h0208,
      16'h0209, 16'h0209, 16'h0209, 16'h0229, 16'h020C, 16'h0208, 16'h020C, 16'h0108, 16'h0108};
   logic [12:0] tp [15] = '{13'h01A0, 13'h01A0, 13'h0180, 13'h0180, 13'h0170, 13'h0193,
      13'h0170, 13'h01A0, 13'h0170, 13'h0170, 13'h01A0, 13'h1FD0, 13'h0703, 13'h0703, 13'h0000};
   logic        asr [15] = '{1, 1, 1, 1, 0, 0, 0, 1, 1, 0, 0, 1, 1, 1, 1};
   logic [15:0] lim [3] = '{16'h0190, 16'h1FF0, 16'h0640};
   // Released alert line is pulled up
   wire logic   alert_pin = alert_pin_oe_n ? 1'b1 : alert_pin_out;

   tlac_core dut (.clk, .reset_n, .link_clk, .link_wr, .link_rd, .link_ptr, .link_wdata,
      .link_rdata, .link_done, .link_busy, .conv_valid, .conv_temp, .conv_enable,
      .alert_pin_out, .alert_pin_oe_n);
   tlac_conv_model conv (.clk, .conv_enable, .temp, .conv_valid, .conv_temp);

   // Clocks at .5 ns and whole ns edges never coincide with stimulus
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      forever #6 link_clk = ~link_clk;
   end

   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One register access; request held until the accepting edge
   task acc(input logic w, input logic [7:0] p, input logic [15:0] d);
      int k;
      @(posedge link_clk) #1;
      link_wr = w;
      link_rd = !w;
      link_ptr = p;
      link_wdata = d;
      @(posedge link_clk) #1;
      link_wr = 1'b0;
      link_rd = 1'b0;
      for (k = 0; k < 20 && link_done !== 1'b1; k++) @(posedge link_clk) #1;
      rd = link_rdata;
      chk("done", {15'h0, link_done}, 16'h0001);
   endtask

   task rst;
      reset_n = 1'b0;
      repeat (12) @(posedge clk);
      #1 reset_n = 1'b1;
      for (i = 1; i < 7; i++) begin
         acc(0, i == 6 ? 8'h09 : 8'(i), 16'h0000);
         chk("reset", rd, 16'h0000);
      end
      $display("test reset done");
   endtask

   task print_verdict;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #100000;
      n_fail++;
      print_verdict;
   end

   initial begin
      rst;
      for (i = 0; i < 4; i++) begin
         acc(1, 8'h01, 16'hF828 | (16'(i) << 9));
         acc(0, 8'h01, 16'h0000);
         chk("fields", rd, 16'h0008 | (16'(i) << 9));
      end
      for (i = 0; i < 3; i++) acc(1, 8'(i + 2), lim[i]);
      $display("test fields done");
      // Each step: new reading, then control write, then pin and status
      for (i = 0; i < 15; i++) begin
         temp = tp[i];
         repeat (80) @(posedge clk);
         acc(1, 8'h01, cw[i]);
         repeat (10) @(posedge clk);
         #1 chk("pin", {15'h0, alert_pin}, {15'h0, asr[i] ? cw[i][1] : 1'b1});
         acc(0, 8'h01, 16'h0000);
         chk("status", rd, (cw[i] & 16'hFFDF) | {11'h0, asr[i], 4'h0});
      end
      $display("test alert done");
      acc(0, 8'h05, 16'h0000);
      chk("reading", rd, 16'hC703);
      chk("conv_en", {15'h0, conv_enable}, 16'h0000);
      acc(1, 8'h01, 16'h00C8);
      repeat (80) @(posedge clk);
      acc(1, 8'h01, 16'h07F5);
      acc(0, 8'h01, 16'h0000);
      chk("locked", rd, 16'h00C9);
      for (i = 0; i < 3; i++) begin
         acc(1, 8'(i + 2), 16'h0AAC);
         acc(0, 8'(i + 2), 16'h0000);
         chk("limit", rd, lim[i]);
      end
      $display("test locks done");
      rst;
      print_verdict;
   end
endmodule // tb_tlac_core

bind tlac_core tlac_core_assertions u_chk (.*);

// ===== bench/tlac_conv_model.sv
`timescale 1ns/100ps
module tlac_conv_model (
   input  wire logic        clk,
   input  wire logic        conv_enable,
   input  wire logic [12:0] temp,
   output logic             conv_valid = 1'b0,
   output logic      [12:0] conv_temp
);
   logic [4:0] tick = 5'h00;
   // One result every 32 cycles, none while powered down
   always @(posedge clk) begin
      tick <= tick + 5'h01;
      conv_valid <= conv_enable && tick == 5'h1F;
   end
   // Between results the data shows a pattern, not the last value
   assign conv_temp = conv_valid ? temp : ~temp;
endmodule // tlac_conv_model

// ===== bench/tlac_core_assertions.sv
`timescale 1ns/100ps
module tlac_core_assertions (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        link_clk,
   input wire logic        link_wr,
   input wire logic        link_rd,
   input wire logic [7:0]  link_ptr,
   input wire logic [15:0] link_rdata,
   input wire logic        link_done,
   input wire logic        link_busy,
   input wire logic        conv_valid,
   input wire logic        conv_enable,
   input wire logic        alert_pin_out,
   input wire logic        alert_pin_oe_n
);
   // Idle port takes a request, then answers in bounded time
   sequence s_acc;
      (link_wr || link_rd) && !link_busy;
   endsequence
   sequence s_answer;
      link_busy ##[1:12] link_done;
   endsequence
   req_answer_a: assert property (@(posedge link_clk) disable iff (!reset_n)
      s_acc |=> s_answer) else $error("request not answered");
   done_pulse_a: assert property (@(posedge link_clk) disable iff (!reset_n)
      link_done |=> !link_done) else $error("done wider than one cycle");
   done_idle_a: assert property (@(posedge link_clk) disable iff (!reset_n)
      link_done |-> !link_busy) else $error("busy during done");
   rdata_hold_a: assert property (@(posedge link_clk) disable iff (!reset_n)
      $changed(link_rdata) |-> link_done) else $error("read word moved");
   ctrl_read_a: assert property (@(posedge link_clk) disable iff (!reset_n)
      link_done && link_ptr == 8'h01 |-> link_rdata[15:11] == 5'h00 && !link_rdata[5])
      else $error("control word reserved or clear bit set");
   limit_read_a: assert property (@(posedge link_clk) disable iff (!reset_n)
      link_done && link_ptr inside {8'h02, 8'h03, 8'h04}
      |-> link_rdata[15:13] == 3'h0 && link_rdata[1:0] == 2'h0)
      else $error("limit unused bits set");
   // Pin moves only after a conversion or a register write
   pin_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
      $changed(alert_pin_oe_n) |-> $past(conv_valid, 3) || $past(conv_valid, 4) ||
      link_busy || $past(link_busy, 4))
      else $error("alert moved without cause");
   pol_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
      $changed(alert_pin_out) |-> link_busy || $past(link_busy, 4))
      else $error("alert level moved without write");
   pd_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
      $changed(conv_enable) |-> link_busy || $past(link_busy, 4) || !$past(reset_n, 2))
      else $error("converter enable moved without write");
endmodule // tlac_core_assertions

// ===== hw/tlac_core.sv
`timescale 1ns/100ps
// What this block does
// - Control word bits 15 to 11 read zero and ignore writes.
// - Margin field bits 10:9 picks hysteresis none, 1.5, 3 or 6 degC.
// - Upper and critical flags clear once reading is at or below threshold minus hysteresis; lower flag clears at or above its limit.
// - Either lock set freezes the margin field.
// - Power down stops conversions, flag and reading updates; alert output holds its state; bus still works.
// - Locks block setting power down; clearing it always works.
// - Critical lock bit 7 freezes critical limit; cleared only by reset.
// - Window lock bit 6 freezes upper and lower limits; reset clears.
// - Writing one to clear bit 5 releases the interrupt latch; reads zero.
// - Clear writes are ignored in comparator mode.
// - Status bit 4 reads one while alert output is asserted.
// - Enable bit 3 gates alert output; locks freeze it.
// - Critical-only bit 2 limits alerts to critical crossings.
// - Window lock freezes the critical-only bit.
// - Polarity bit 1 selects asserted level low or high.
// - Mode bit 0 selects comparator or interrupt operation.
// - Limits and reading are two's complement; limits define bits 12 to 2, reading bits 12 to 0.
// - Comparisons use reading bits 12 to 2; reads show all bits.
// - Upper limit holds sign at bit 12 down to 0.25 degC, reset zero.
// - Alert on rising above upper limit and on falling back.
// - Alert on falling below lower limit minus hysteresis and on rising back to the limit.
// - Critical alert holds until reading at or below limit minus hysteresis.
module tlac_core
   import tlac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        link_clk,
   input  wire logic        link_wr,
   input  wire logic        link_rd,
   input  wire logic [7:0]  link_ptr,
   input  wire logic [15:0] link_wdata,
   output logic      [15:0] link_rdata,
   output logic             link_done,
   output logic             link_busy,
   input  wire logic        conv_valid,
   input  wire logic [12:0] conv_temp,
   output logic             conv_enable,
   output logic             alert_pin_out,
   output logic             alert_pin_oe_n
);

   // Request crossing
   logic                       req_toggle;
   logic                       req_write;
   logic [7:0]                 req_ptr;
   logic [15:0]                req_wdata;
   logic                       req_sync1;
   logic                       req_sync2;
   logic                       req_seen;
   logic                       req_edge;
   logic                       ack_toggle;
   logic [15:0]                ack_rdata;
   logic [15:0]                next_rd_data;

   // Control word state
   tlac_margin_t               limit_margin_select;
   logic                       sensor_power_down;
   logic                       critical_limit_lock;
   logic                       window_limit_lock;
   logic                       alert_output_enable;
   logic                       critical_only_alert;
   logic                       alert_polarity;
   logic                       alert_mode_select;
   logic                       alert_output_status;
   logic                       lock_any;
   logic                       ctrl_write;
   logic                       clear_pulse;

   // Limits and reading
   logic [TLAC_CMP_W-1:0]      upper_window_limit;
   logic [TLAC_CMP_W-1:0]      lower_window_limit;
   logic [TLAC_CMP_W-1:0]      critical_limit;
   logic [TLAC_CMP_W-1:0]      limit_value [TLAC_NUM_LIMITS];
   logic [TLAC_TEMP_W-1:0]     reading_raw;
   logic [TLAC_STEP_W-1:0]     margin_steps;
   logic                       eval_pulse;
   logic                       eval_done;

   // Flags and alert
   logic [TLAC_NUM_LIMITS-1:0] limit_flag;
   logic [TLAC_NUM_LIMITS-1:0] flag_prev;
   logic                       window_event;
   logic                       irq_latch;
   logic                       limit_condition;
   logic                       next_alert;

   // Link-side half of the register port, on the link clock
   tlac_link_port u_link_port (
      .link_clk   (link_clk),
      .reset_n    (reset_n),
      .link_wr    (link_wr),
      .link_rd    (link_rd),
      .link_ptr   (link_ptr),
      .link_wdata (link_wdata),
      .link_rdata (link_rdata),
      .link_done  (link_done),
      .link_busy  (link_busy),
      .req_toggle (req_toggle),
      .req_write  (req_write),
      .req_ptr    (req_ptr),
      .req_wdata  (req_wdata),
      .ack_toggle (ack_toggle),
      .ack_rdata  (ack_rdata)
   );

   // Request toggle synchroniser; third stage only for the edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         req_sync1 <= 1'b0;
         req_sync2 <= 1'b0;
         req_seen  <= 1'b0;
      end else begin
         req_sync1 <= req_toggle;
         req_sync2 <= req_sync1;
         req_seen  <= req_sync2;
      end
   end

   // Pointer and data are held by the link side until the answer
   assign req_edge   = req_sync2 ^ req_seen;
   assign ctrl_write = req_edge && req_write && (req_ptr == TLAC_PTR_CTRL);
   assign lock_any   = critical_limit_lock | window_limit_lock;

   // Control word update; locks are sticky until reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         limit_margin_select <= tlac_margin_t'(TLAC_CTRL_RESET[TLAC_CW_MARGIN_HI:TLAC_CW_MARGIN_LO]);
         sensor_power_down   <= TLAC_CTRL_RESET[TLAC_CW_PD];
         critical_limit_lock <= TLAC_CTRL_RESET[TLAC_CW_CLOCK];
         window_limit_lock   <= TLAC_CTRL_RESET[TLAC_CW_WLOCK];
         alert_output_enable <= TLAC_CTRL_RESET[TLAC_CW_EN];
         critical_only_alert <= TLAC_CTRL_RESET[TLAC_CW_CRONLY];
         alert_polarity      <= TLAC_CTRL_RESET[TLAC_CW_POL];
         alert_mode_select   <= TLAC_CTRL_RESET[TLAC_CW_MODE];
      end else if (ctrl_write) begin
         if (!lock_any) begin
            limit_margin_select <= tlac_margin_t'(req_wdata[TLAC_CW_MARGIN_HI:TLAC_CW_MARGIN_LO]);
         end
         if (!req_wdata[TLAC_CW_PD]) begin
            sensor_power_down <= 1'b0;
         end else if (!lock_any) begin
            sensor_power_down <= 1'b1;
         end
         if (req_wdata[TLAC_CW_CLOCK]) begin
            critical_limit_lock <= 1'b1;
         end
         if (req_wdata[TLAC_CW_WLOCK]) begin
            window_limit_lock <= 1'b1;
         end
         if (!lock_any) begin
            alert_output_enable <= req_wdata[TLAC_CW_EN];
         end
         if (!window_limit_lock) begin
            critical_only_alert <= req_wdata[TLAC_CW_CRONLY];
         end
         alert_polarity    <= req_wdata[TLAC_CW_POL];
         alert_mode_select <= req_wdata[TLAC_CW_MODE];
      end
   end

   // Clear is a one-cycle strobe, never stored, so it reads back zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clear_pulse <= 1'b0;
      end else begin
         clear_pulse <= ctrl_write && req_wdata[TLAC_CW_CLEAR] && alert_mode_select;
      end
   end

   // Window limits; only bits 12 to 2 are kept, the rest read zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         upper_window_limit <= TLAC_LIMIT_RESET;
         lower_window_limit <= TLAC_LIMIT_RESET;
      end else if (req_edge && req_write && !window_limit_lock) begin
         if (req_ptr == TLAC_PTR_UPPER) begin
            upper_window_limit <= req_wdata[TLAC_LIM_MSB:TLAC_LIM_LSB];
         end
         if (req_ptr == TLAC_PTR_LOWER) begin
            lower_window_limit <= req_wdata[TLAC_LIM_MSB:TLAC_LIM_LSB];
         end
      end
   end

   // Critical limit, same layout as the window limits
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         critical_limit <= TLAC_LIMIT_RESET;
      end else if (req_edge && req_write && !critical_limit_lock &&
                   (req_ptr == TLAC_PTR_CRIT)) begin
         critical_limit <= req_wdata[TLAC_LIM_MSB:TLAC_LIM_LSB];
      end
   end

   // Register read multiplexer
   always_comb begin
      next_rd_data = 16'h0000;
      case (req_ptr)
         TLAC_PTR_CTRL: begin
            next_rd_data[TLAC_CW_RSVD_HI:TLAC_CW_RSVD_LO]     = 5'h00;
            next_rd_data[TLAC_CW_MARGIN_HI:TLAC_CW_MARGIN_LO] = limit_margin_select;
            next_rd_data[TLAC_CW_PD]     = sensor_power_down;
            next_rd_data[TLAC_CW_CLOCK]  = critical_limit_lock;
            next_rd_data[TLAC_CW_WLOCK]  = window_limit_lock;
            next_rd_data[TLAC_CW_CLEAR]  = 1'b0;
            next_rd_data[TLAC_CW_STS]    = alert_output_status;
            next_rd_data[TLAC_CW_EN]     = alert_output_enable;
            next_rd_data[TLAC_CW_CRONLY] = critical_only_alert;
            next_rd_data[TLAC_CW_POL]    = alert_polarity;
            next_rd_data[TLAC_CW_MODE]   = alert_mode_select;
         end
         TLAC_PTR_UPPER: begin
            next_rd_data[TLAC_LIM_MSB:TLAC_LIM_LSB] = upper_window_limit;
         end
         TLAC_PTR_LOWER: begin
            next_rd_data[TLAC_LIM_MSB:TLAC_LIM_LSB] = lower_window_limit;
         end
         TLAC_PTR_CRIT: begin
            next_rd_data[TLAC_LIM_MSB:TLAC_LIM_LSB] = critical_limit;
         end
         TLAC_PTR_READING: begin
            next_rd_data[TLAC_TEMP_W-1:0] = reading_raw;
            next_rd_data[TLAC_ST_CRIT]    = limit_flag[TLAC_FLAG_CRIT];
            next_rd_data[TLAC_ST_CRIT-1]  = limit_flag[TLAC_FLAG_HIGH];
            next_rd_data[TLAC_ST_CRIT-2]  = limit_flag[TLAC_FLAG_LOW];
         end
         default: begin
            next_rd_data = 16'h0000;
         end
      endcase
   end

   // Answer word and toggle go back together; the link samples after sync
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_rdata  <= 16'h0000;
         ack_toggle <= 1'b0;
      end else if (req_edge) begin
         ack_rdata  <= next_rd_data;
         ack_toggle <= ~ack_toggle;
      end
   end

   // Converter runs only while not powered down
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         conv_enable <= 1'b0;
      end else begin
         conv_enable <= ~sensor_power_down;
      end
   end

   // Reading freezes in power down; results landing then are dropped
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reading_raw <= TLAC_READING_RESET;
         eval_pulse  <= 1'b0;
         eval_done   <= 1'b0;
      end else begin
         eval_pulse <= conv_valid && !sensor_power_down;
         eval_done  <= eval_pulse;
         if (conv_valid && !sensor_power_down) begin
            reading_raw <= conv_temp;
         end
      end
   end

   // Hysteresis in quarter-degree steps
   always_comb begin
      margin_steps = TLAC_STEP_NONE;
      unique case (limit_margin_select)
         TLAC_MARGIN_NONE: margin_steps = TLAC_STEP_NONE;
         TLAC_MARGIN_1P5:  margin_steps = TLAC_STEP_1P5;
         TLAC_MARGIN_3:    margin_steps = TLAC_STEP_3;
         TLAC_MARGIN_6:    margin_steps = TLAC_STEP_6;
      endcase
   end

   assign limit_value[TLAC_FLAG_LOW]  = lower_window_limit;
   assign limit_value[TLAC_FLAG_HIGH] = upper_window_limit;
   assign limit_value[TLAC_FLAG_CRIT] = critical_limit;

   // One comparator per limit; only the lower limit senses downward
   for (genvar i = 0; i < TLAC_NUM_LIMITS; i++) begin : g_limit
      tlac_limit_flag u_flag (
         .clk         (clk),
         .reset_n     (reset_n),
         .eval        (eval_pulse),
         .upper_sense (i != TLAC_FLAG_LOW),
         .reading     (reading_raw[TLAC_LIM_MSB:TLAC_LIM_LSB]),
         .limit       (limit_value[i]),
         .margin      (margin_steps),
         .flag        (limit_flag[i])
      );
   end

   // Any change of a window flag is an interrupt event unless disabled or critical-only
   assign window_event = eval_done && alert_output_enable && !critical_only_alert &&
                         ((limit_flag[TLAC_FLAG_HIGH] ^ flag_prev[TLAC_FLAG_HIGH]) ||
                          (limit_flag[TLAC_FLAG_LOW] ^ flag_prev[TLAC_FLAG_LOW]));

   // Previous flags, sampled once per evaluation
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_prev <= '0;
      end else if (eval_done) begin
         flag_prev <= limit_flag;
      end
   end

   // Interrupt latch: a new event beats a clear arriving in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_latch <= 1'b0;
      end else if (window_event) begin
         irq_latch <= 1'b1;
      end else if (clear_pulse || !alert_mode_select) begin
         irq_latch <= 1'b0;
      end
   end

   // Critical stays a level even in interrupt mode, so clear cannot hide it
   assign limit_condition = limit_flag[TLAC_FLAG_CRIT] ||
                            (!critical_only_alert &&
                             (limit_flag[TLAC_FLAG_HIGH] || limit_flag[TLAC_FLAG_LOW]));
   assign next_alert = alert_output_enable &&
                       (alert_mode_select ? (irq_latch || limit_flag[TLAC_FLAG_CRIT])
                                          : limit_condition);

   // Pin driven only while asserted; released pin is left to the pull-up
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         alert_output_status <= 1'b0;
         alert_pin_oe_n      <= 1'b1;
         alert_pin_out       <= 1'b0;
      end else begin
         alert_output_status <= next_alert;
         alert_pin_oe_n      <= ~next_alert;
         alert_pin_out       <= alert_polarity;
      end
   end

endmodule // tlac_core

// ===== hw/tlac_limit_flag.sv
`timescale 1ns/100ps
module tlac_limit_flag
   import tlac_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   eval,
   input  wire logic                   upper_sense,
   input  wire logic [TLAC_CMP_W-1:0]  reading,
   input  wire logic [TLAC_CMP_W-1:0]  limit,
   input  wire logic [TLAC_STEP_W-1:0] margin,
   output logic                        flag
);

   logic signed [12:0] reading_x;
   logic signed [12:0] limit_x;
   logic signed [12:0] limit_low;

   // Two guard bits so that limit minus margin cannot wrap
   assign reading_x = {{2{reading[TLAC_CMP_W-1]}}, reading};
   assign limit_x   = {{2{limit[TLAC_CMP_W-1]}}, limit};
   assign limit_low = limit_x - $signed({8'h00, margin});

   // Margin only acts on the falling side of the threshold
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag <= 1'b0;
      end else if (eval) begin
         if (upper_sense) begin
            if (reading_x > limit_x) begin
               flag <= 1'b1;
            end else if (reading_x <= limit_low) begin
               flag <= 1'b0;
            end
         end else begin
            if (reading_x < limit_low) begin
               flag <= 1'b1;
            end else if (reading_x >= limit_x) begin
               flag <= 1'b0;
            end
         end
      end
   end

endmodule // tlac_limit_flag

// ===== hw/tlac_link_port.sv
`timescale 1ns/100ps
module tlac_link_port (
   input  wire logic        link_clk,
   input  wire logic        reset_n,
   input  wire logic        link_wr,
   input  wire logic        link_rd,
   input  wire logic [7:0]  link_ptr,
   input  wire logic [15:0] link_wdata,
   output logic      [15:0] link_rdata,
   output logic             link_done,
   output logic             link_busy,
   output logic             req_toggle,
   output logic             req_write,
   output logic      [7:0]  req_ptr,
   output logic      [15:0] req_wdata,
   input  wire logic        ack_toggle,
   input  wire logic [15:0] ack_rdata
);

   logic ack_sync1;
   logic ack_sync2;
   logic ack_seen;
   logic ack_edge;

   // Answer toggle from the device clock, two stages before use
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_sync1 <= 1'b0;
         ack_sync2 <= 1'b0;
         ack_seen  <= 1'b0;
      end else begin
         ack_sync1 <= ack_toggle;
         ack_sync2 <= ack_sync1;
         ack_seen  <= ack_sync2;
      end
   end

   assign ack_edge = ack_sync2 ^ ack_seen;

   // Request is held stable until answered; requests while busy are dropped
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_toggle <= 1'b0;
         req_write  <= 1'b0;
         req_ptr    <= 8'h00;
         req_wdata  <= 16'h0000;
         link_busy  <= 1'b0;
      end else if (!link_busy && (link_wr || link_rd)) begin
         req_toggle <= ~req_toggle;
         req_write  <= link_wr;
         req_ptr    <= link_ptr;
         req_wdata  <= link_wdata;
         link_busy  <= 1'b1;
      end else if (ack_edge) begin
         link_busy  <= 1'b0;
      end
   end

   // Read word is stable by the time the answer toggle arrives
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         link_rdata <= 16'h0000;
         link_done  <= 1'b0;
      end else begin
         link_done <= ack_edge;
         if (ack_edge) begin
            link_rdata <= ack_rdata;
         end
      end
   end

endmodule // tlac_link_port

// ===== hw/tlac_pkg.sv
package tlac_pkg;

   // Register pointers as seen by the serial bus engine
   localparam logic [7:0]  TLAC_PTR_CTRL      = 8'h01;
   localparam logic [7:0]  TLAC_PTR_UPPER     = 8'h02;
   localparam logic [7:0]  TLAC_PTR_LOWER     = 8'h03;
   localparam logic [7:0]  TLAC_PTR_CRIT      = 8'h04;
   localparam logic [7:0]  TLAC_PTR_READING   = 8'h05;

   // Control word field positions
   localparam int          TLAC_CW_RSVD_HI    = 15;
   localparam int          TLAC_CW_RSVD_LO    = 11;
   localparam int          TLAC_CW_MARGIN_HI  = 10;
   localparam int          TLAC_CW_MARGIN_LO  = 9;
   localparam int          TLAC_CW_PD         = 8;
   localparam int          TLAC_CW_CLOCK      = 7;
   localparam int          TLAC_CW_WLOCK      = 6;
   localparam int          TLAC_CW_CLEAR      = 5;
   localparam int          TLAC_CW_STS        = 4;
   localparam int          TLAC_CW_EN         = 3;
   localparam int          TLAC_CW_CRONLY     = 2;
   localparam int          TLAC_CW_POL        = 1;
   localparam int          TLAC_CW_MODE       = 0;

   // Temperature word layout: comparisons use bits 12 down to 2
   localparam int          TLAC_TEMP_W        = 13;
   localparam int          TLAC_LIM_MSB       = 12;
   localparam int          TLAC_LIM_LSB       = 2;
   localparam int          TLAC_CMP_W         = 11;
   localparam int          TLAC_ST_CRIT       = 15;

   // Reset values
   localparam logic [15:0] TLAC_CTRL_RESET    = 16'h0000;
   localparam logic [10:0] TLAC_LIMIT_RESET   = 11'h000;
   localparam logic [12:0] TLAC_READING_RESET = 13'h0000;

   // Hysteresis in steps of 0.25 degC: 0, 1.5, 3 and 6 degC
   localparam int          TLAC_STEP_W        = 5;
   localparam logic [4:0]  TLAC_STEP_NONE     = 5'h00;
   localparam logic [4:0]  TLAC_STEP_1P5      = 5'h06;
   localparam logic [4:0]  TLAC_STEP_3        = 5'h0C;
   localparam logic [4:0]  TLAC_STEP_6        = 5'h18;

   // Limit flag indices
   localparam int          TLAC_NUM_LIMITS    = 3;
   localparam int          TLAC_FLAG_LOW      = 0;
   localparam int          TLAC_FLAG_HIGH     = 1;
   localparam int          TLAC_FLAG_CRIT     = 2;

   typedef enum logic [1:0] {
      TLAC_MARGIN_NONE,
      TLAC_MARGIN_1P5,
      TLAC_MARGIN_3,
      TLAC_MARGIN_6
   } tlac_margin_t;

endpackage
